// [design/tdss_pkg.sv]
// tdss_pkg: shared constants of the trigger delay sample sequencer.
// assumes a 200 MHz core clock; the sample pulse counts are derived from it here, the sequencer phase step is fixed.
package tdss_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// core clock
	localparam int CORE_PERIOD_PS = 5000;

	// sequencer clock 39.0625 MHz = 200 MHz * 25 / 128, made by a phase accumulator
	localparam logic [6:0] SEQ_PHASE_INC  = 7'h19;
	localparam logic [6:0] SEQ_PHASE_HALF = 7'h40;
	localparam logic [6:0] SEQ_PHASE_RST  = 7'h00;
	localparam int         SEQ_PERIOD_PS  = 25600;

	////////////////////////////////////////////////////////////////////////////////
	// fine delay code: 0 to 25.5 ns in 0.1 ns steps
	localparam int         FINE_CODE_W   = 8;
	localparam int         FINE_STEP_PS  = 100;
	localparam logic [7:0] FINE_CODE_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// pulse widths
	localparam int PULSE_W        = 20;
	localparam int SAMPLE1_NS     = 15;
	localparam int SAMPLE1_CYC    = (SAMPLE1_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
	localparam int SAMPLE2_NS     = 4300000;
	localparam int SAMPLE2_CYC    = SAMPLE2_NS / (CORE_PERIOD_PS / 1000);
	localparam logic [19:0] PULSE_ZERO = 20'h00000;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer states
	typedef enum logic [2:0] {
		SEQ_ARMED,
		SEQ_WAIT_FALL,
		SEQ_COUNT,
		SEQ_FINE,
		SEQ_SAMPLED
	} tdss_state_t;

endpackage

// [design/tdss_pulse_timer.sv]
// tdss_pulse_timer: one-shot pulse of a programmable number of core cycles.
// assumes start is a one-cycle pulse on core_clk; retrigger while busy is ignored.
`timescale 1ns/1ps
module tdss_pulse_timer (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// control
	input  wire logic        start,
	input  wire logic [19:0] width,
	// pulse
	output logic             pulse_q
);

	logic [19:0] left_q;
	logic [19:0] left_d;
	logic        pulse_d;

	////////////////////////////////////////////////////////////////////////////////
	// next count and pulse level
	always_comb begin
		left_d  = left_q;
		pulse_d = pulse_q;
		if (start && !pulse_q) begin
			left_d  = width - 20'h00001;
			pulse_d = 1'b1;
		end else if (pulse_q) begin
			if (left_q == tdss_pkg::PULSE_ZERO) begin
				pulse_d = 1'b0;
			end else begin
				left_d = left_q - 20'h00001;
			end
		end
	end

	// registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			left_q  <= tdss_pkg::PULSE_ZERO;
			pulse_q <= 1'b0;
		end else begin
			left_q  <= left_d;
			pulse_q <= pulse_d;
		end
	end

endmodule

// [design/tdss_sequencer.sv]
// tdss_sequencer: trigger, ramp, sample and interrupt sequencing of the delay board.
// assumes trigger, terminal count and comparator arrive asynchronously from pins;
// host reset, acknowledge and delay load come from logic on core_clk.
`timescale 1ns/1ps
module tdss_sequencer #(
	parameter int SAMPLE2_CYCLES = tdss_pkg::SAMPLE2_CYC
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// host side
	input  wire logic        hostBoardReset,
	input  wire logic        newDataAck,
	input  wire logic        fineDelayLoad,
	input  wire logic [7:0]  fineDelayCode,
	output logic             irqReq_q,
	output logic             haltActive_q,
	output logic [7:0]       fineDelayDac_q,
	// analog and counter side
	input  wire logic        trigIn,
	input  wire logic        coarseTc,
	input  wire logic        cmpDone,
	output logic             rampOn_q,
	output logic             counterEn_q,
	output logic             holdStart_q,
	output logic             clkGateOn_q,
	output logic             cmpFrozen_q,
	output logic             readyOut_q,
	output logic             armed_status_out_q,
	// sample pulses
	output logic             sample1,
	output logic             syncOut,
	output logic             sample2
);

	////////////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for pin inputs
	logic [1:0] trigSync_q;
	logic [1:0] tcSync_q;
	logic [1:0] cmpSync_q;
	logic       trigPrev_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			trigSync_q <= 2'h3; // a trigger already high at reset is no edge
			tcSync_q   <= 2'h0;
			cmpSync_q  <= 2'h0;
			trigPrev_q <= 1'b1;
		end else begin
			trigSync_q <= {trigSync_q[0], trigIn};
			tcSync_q   <= {tcSync_q[0], coarseTc};
			cmpSync_q  <= {cmpSync_q[0], cmpDone};
			trigPrev_q <= trigSync_q[1];
		end
	end

	wire trigRise = trigSync_q[1] && !trigPrev_q;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer clock phase: fall enable only, at 39.0625 MHz
	logic [6:0] phase_q;
	logic [6:0] phase_d;
	logic       seqFall;

	always_comb begin
		phase_d = phase_q + tdss_pkg::SEQ_PHASE_INC;
		seqFall = (phase_q < tdss_pkg::SEQ_PHASE_HALF) &&
			(phase_d >= tdss_pkg::SEQ_PHASE_HALF);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase_q <= tdss_pkg::SEQ_PHASE_RST;
		end else begin
			phase_q <= phase_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pulse shaper timers
	logic sampleFire;
	logic s1Pulse;
	logic s2Pulse;
	logic s2Prev_q;

	tdss_pulse_timer u_sample1 (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.start    (sampleFire),
		.width    (20'(tdss_pkg::SAMPLE1_CYC)),
		.pulse_q  (s1Pulse)
	);

	tdss_pulse_timer u_sample2 (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.start    (sampleFire),
		.width    (20'(SAMPLE2_CYCLES)),
		.pulse_q  (s2Pulse)
	);

	assign sample1 = s1Pulse;
	assign syncOut = s1Pulse;
	assign sample2 = s2Pulse;

	wire s2Rise = s2Pulse && !s2Prev_q;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer state and outputs
	tdss_pkg::tdss_state_t state_q;
	tdss_pkg::tdss_state_t state_d;
	logic blocked_q;
	logic blocked_d;
	logic rampOn_d;
	logic counterEn_d;
	logic holdStart_d;
	logic clkGateOn_d;
	logic cmpFrozen_d;
	logic readyOut_d;
	logic armed_d;
	logic irq_d;
	logic halt_d;
	logic [7:0] fine_d;

	always_comb begin
		state_d     = state_q;
		blocked_d   = blocked_q;
		rampOn_d    = rampOn_q;
		counterEn_d = counterEn_q;
		holdStart_d = 1'b0;
		clkGateOn_d = clkGateOn_q;
		cmpFrozen_d = cmpFrozen_q;
		readyOut_d  = readyOut_q;
		armed_d     = armed_status_out_q;
		halt_d      = haltActive_q;
		fine_d      = fineDelayDac_q;
		sampleFire  = 1'b0;
		if (fineDelayLoad) begin
			fine_d = fineDelayCode;
		end
		case (state_q)
			tdss_pkg::SEQ_ARMED: begin
				if (trigRise && !blocked_q) begin
					state_d     = tdss_pkg::SEQ_WAIT_FALL;
					rampOn_d    = 1'b1;
					counterEn_d = 1'b1;
					holdStart_d = 1'b1;
					armed_d     = 1'b0;
					halt_d      = 1'b1;
				end
			end
			tdss_pkg::SEQ_WAIT_FALL: begin
				if (seqFall) begin
					state_d     = tdss_pkg::SEQ_COUNT;
					rampOn_d    = 1'b0;
					clkGateOn_d = 1'b1;
				end
			end
			tdss_pkg::SEQ_COUNT: begin
				if (tcSync_q[1]) begin
					state_d  = tdss_pkg::SEQ_FINE;
					rampOn_d = 1'b1;
				end
			end
			tdss_pkg::SEQ_FINE: begin
				if (cmpSync_q[1]) begin
					state_d     = tdss_pkg::SEQ_SAMPLED;
					rampOn_d    = 1'b0;
					clkGateOn_d = 1'b0;
					counterEn_d = 1'b0;
					cmpFrozen_d = 1'b1;
					readyOut_d  = 1'b1;
					armed_d     = 1'b1;
					sampleFire  = 1'b1;
				end
			end
			tdss_pkg::SEQ_SAMPLED: begin
				state_d = tdss_pkg::SEQ_SAMPLED; // held until board reset
			end
			default: begin
				state_d = tdss_pkg::SEQ_ARMED;
			end
		endcase
		if (hostBoardReset) begin
			state_d     = tdss_pkg::SEQ_ARMED;
			blocked_d   = 1'b0;
			rampOn_d    = 1'b0;
			counterEn_d = 1'b0;
			clkGateOn_d = 1'b0;
			cmpFrozen_d = 1'b0;
			readyOut_d  = 1'b0;
			armed_d     = 1'b1;
		end
		// sample2 set wins over a coincident board reset
		if (s2Rise) begin
			blocked_d = 1'b1;
			halt_d    = 1'b0;
		end
		// set wins over acknowledge
		irq_d = s2Rise || (irqReq_q && !newDataAck);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q            <= tdss_pkg::SEQ_ARMED;
			blocked_q          <= 1'b0;
			rampOn_q           <= 1'b0;
			counterEn_q        <= 1'b0;
			holdStart_q        <= 1'b0;
			clkGateOn_q        <= 1'b0;
			cmpFrozen_q        <= 1'b0;
			readyOut_q         <= 1'b0;
			armed_status_out_q <= 1'b1;
			irqReq_q           <= 1'b0;
			haltActive_q       <= 1'b0;
			fineDelayDac_q     <= tdss_pkg::FINE_CODE_RST;
			s2Prev_q           <= 1'b0;
		end else begin
			state_q            <= state_d;
			blocked_q          <= blocked_d;
			rampOn_q           <= rampOn_d;
			counterEn_q        <= counterEn_d;
			holdStart_q        <= holdStart_d;
			clkGateOn_q        <= clkGateOn_d;
			cmpFrozen_q        <= cmpFrozen_d;
			readyOut_q         <= readyOut_d;
			armed_status_out_q <= armed_d;
			irqReq_q           <= irq_d;
			haltActive_q       <= halt_d;
			fineDelayDac_q     <= fine_d;
			s2Prev_q           <= s2Pulse;
		end
	end

endmodule

// [tb/tdss_seq_chk.sv]
// tdss_seq_chk: port-level timing checks of the sequencer.
// assumes one clock core_clk and the sync reset sys_rst.
`timescale 1ns/1ps
module tdss_seq_chk #(
	parameter int SAMPLE2_CYCLES = 40
) (
	// watched ports
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic newDataAck,
	input wire logic irqReq_q,
	input wire logic haltActive_q,
	input wire logic rampOn_q,
	input wire logic counterEn_q,
	input wire logic holdStart_q,
	input wire logic clkGateOn_q,
	input wire logic cmpFrozen_q,
	input wire logic readyOut_q,
	input wire logic armed_status_out_q,
	input wire logic sample1,
	input wire logic syncOut,
	input wire logic sample2
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [19:0] s2Len_q;
	////////////////////////////////////////////////////////////////////////////////
	// length of the running second sample pulse
	always_ff @(posedge core_clk) begin
		s2Len_q <= sample2 ? s2Len_q + 20'h00001 : 20'h00000;
	end
	////////////////////////////////////////////////////////////////////////////////
	// sequencing, pulse and interrupt rules seen at the ports
	trig_start_a: assert property (
		$rose(holdStart_q) |-> rampOn_q && counterEn_q && haltActive_q && !armed_status_out_q
	) else $error("trigger step incomplete");
	gate_open_a: assert property (
		holdStart_q |-> ##[1:8] ($rose(clkGateOn_q) && !rampOn_q)
	) else $error("gate not opened");
	sync_match_a: assert property (
		syncOut == sample1
	) else $error("sync differs from sample1");
	s1_width_a: assert property (
		$rose(sample1) |-> sample1[*3] ##1 !sample1
	) else $error("sample1 width wrong");
	sample_state_a: assert property (
		$rose(sample1) |-> readyOut_q && cmpFrozen_q && armed_status_out_q && !rampOn_q
	) else $error("sample step incomplete");
	s2_width_a: assert property (
		$fell(sample2) |-> s2Len_q == 20'(SAMPLE2_CYCLES)
	) else $error("sample2 width wrong");
	irq_set_a: assert property (
		$rose(sample2) |=> irqReq_q && !haltActive_q
	) else $error("irq not raised");
	irq_clear_a: assert property (
		$fell(irqReq_q) |-> $past(newDataAck)
	) else $error("irq dropped without ack");
	no_retrig_a: assert property (
		readyOut_q |-> !holdStart_q
	) else $error("trigger while blocked");
endmodule
bind tdss_sequencer tdss_seq_chk #(.SAMPLE2_CYCLES(SAMPLE2_CYCLES)) chk (
	.core_clk(core_clk), .sys_rst(sys_rst), .newDataAck(newDataAck), .irqReq_q(irqReq_q),
	.haltActive_q(haltActive_q), .rampOn_q(rampOn_q), .counterEn_q(counterEn_q),
	.holdStart_q(holdStart_q), .clkGateOn_q(clkGateOn_q), .cmpFrozen_q(cmpFrozen_q),
	.readyOut_q(readyOut_q), .armed_status_out_q(armed_status_out_q), .sample1(sample1),
	.syncOut(syncOut), .sample2(sample2));

// [tb/tdss_analog_model.sv]
// tdss_analog_model: coarse counter and ramp comparator seen from the pins.
// assumes the sequencer's enables arrive on core_clk.
`timescale 1ns/1ps
module tdss_analog_model (
	// clock
	input wire logic       core_clk,
	// sequencer side
	input wire logic       counterEn_q,
	input wire logic       clkGateOn_q,
	input wire logic       rampOn_q,
	input wire logic [7:0] fineDelayDac_q,
	// bench control
	input wire logic [7:0] tcDelay,
	input wire logic       spur,
	// pins
	output logic           coarseTc,
	output logic           cmpDone
);
	logic [7:0] cnt_q;
	logic       done_q;
	////////////////////////////////////////////////////////////////////////////////
	// count gated clocks, then the fine ramp time
	always_ff @(posedge core_clk) begin
		if (!counterEn_q) begin
			cnt_q    <= 8'h00;
			coarseTc <= 1'b0;
			done_q   <= 1'b0;
		end else if (clkGateOn_q && !coarseTc && cnt_q == tcDelay) begin
			coarseTc <= 1'b1;
			cnt_q    <= 8'h00;
		end else if (clkGateOn_q && !coarseTc) begin
			cnt_q <= cnt_q + 8'h01;
		end else if (coarseTc && rampOn_q && cnt_q == {4'h0, fineDelayDac_q[7:4]}) begin
			done_q <= 1'b1;
		end else if (coarseTc && rampOn_q) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	// comparator pin: fine ramp done, or a forced spurious level
	assign cmpDone = done_q | spur;
endmodule

// [tb/tdss_sequencer_tb.sv]
// tdss_sequencer_tb: self-checking bench of the sequencer.
// assumes the analog model drives the counter and comparator pins.
`timescale 1ns/1ps
module tdss_sequencer_tb;
	localparam int S2 = 40;
	logic core_clk = 1'b0, sys_rst = 1'b1, hostBoardReset = 1'b0, newDataAck = 1'b0;
	logic fineDelayLoad = 1'b0, trigIn = 1'b0, spur = 1'b0;
	logic [7:0] fineDelayCode = 8'h00, tcDelay = 8'h05, fineDelayDac_q;
	logic irqReq_q, haltActive_q, coarseTc, cmpDone, rampOn_q, counterEn_q, holdStart_q;
	logic clkGateOn_q, cmpFrozen_q, readyOut_q, armed_status_out_q, sample1, syncOut, sample2;
	int mismatches = 0;
	int checks = 0;
	tdss_sequencer #(.SAMPLE2_CYCLES(S2)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
		.hostBoardReset(hostBoardReset), .newDataAck(newDataAck), .fineDelayLoad(fineDelayLoad),
		.fineDelayCode(fineDelayCode), .irqReq_q(irqReq_q), .haltActive_q(haltActive_q),
		.fineDelayDac_q(fineDelayDac_q), .trigIn(trigIn), .coarseTc(coarseTc), .cmpDone(cmpDone),
		.rampOn_q(rampOn_q), .counterEn_q(counterEn_q), .holdStart_q(holdStart_q),
		.clkGateOn_q(clkGateOn_q), .cmpFrozen_q(cmpFrozen_q), .readyOut_q(readyOut_q),
		.armed_status_out_q(armed_status_out_q), .sample1(sample1), .syncOut(syncOut),
		.sample2(sample2));
	tdss_analog_model far (.core_clk(core_clk), .counterEn_q(counterEn_q),
		.clkGateOn_q(clkGateOn_q), .rampOn_q(rampOn_q), .fineDelayDac_q(fineDelayDac_q),
		.tcDelay(tcDelay), .spur(spur), .coarseTc(coarseTc), .cmpDone(cmpDone));
	always #2.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////
	// common tasks
	task automatic results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [19:0] e, input logic [19:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic loadDelay();
		logic [7:0] codes[2] = '{8'hff, 8'h40};
		foreach (codes[k]) begin
			fineDelayCode = codes[k];
			fineDelayLoad = 1'b1;
			step(1);
			fineDelayLoad = 1'b0;
			step(1);
			cmp("dac", codes[k], fineDelayDac_q);
		end
	endtask
	task automatic trigRun(input logic [7:0] tcd);
		int i;
		int w1;
		tcDelay = tcd;
		trigIn = 1'b1;
		for (i = 0; i < 20 && holdStart_q !== 1'b1; i++) step(1);
		cmp("hold", 1, holdStart_q);
		cmp("ramp", 1, rampOn_q);
		cmp("count", 1, counterEn_q);
		cmp("armed", 0, armed_status_out_q);
		cmp("halt", 1, haltActive_q);
		for (i = 0; i < 20 && clkGateOn_q !== 1'b1; i++) step(1);
		cmp("gate", 1, clkGateOn_q);
		cmp("holdend", 0, holdStart_q);
		cmp("rampoff", 0, rampOn_q);
		for (i = 0; i < 300 && coarseTc !== 1'b1; i++) step(1);
		step(4);
		cmp("rampre", 1, rampOn_q);
		for (i = 0; i < 30 && sample1 !== 1'b1; i++) step(1);
		cmp("sync", 1, syncOut);
		cmp("ready", 1, readyOut_q);
		cmp("armedup", 1, armed_status_out_q);
		cmp("frozen", 1, cmpFrozen_q);
		cmp("gateoff", 0, clkGateOn_q);
		cmp("cntoff", 0, counterEn_q);
		trigIn = 1'b0;
		w1 = 0;
		for (i = 0; i < 100 && sample2 === 1'b1; i++) begin
			w1 += sample1;
			step(1);
		end
		cmp("s1w", 3, w1);
		cmp("s2w", S2, i);
		cmp("irq", 1, irqReq_q);
		cmp("haltend", 0, haltActive_q);
	endtask
	task automatic blocked();
		trigIn = 1'b1;
		spur = 1'b1;
		step(12);
		cmp("noarm", 1, armed_status_out_q);
		cmp("nohalt", 0, haltActive_q);
		cmp("nos1", 0, sample1);
		cmp("irqheld", 1, irqReq_q);
	endtask
	task automatic ackReset();
		newDataAck = 1'b1;
		step(1);
		newDataAck = 1'b0;
		cmp("irqclr", 0, irqReq_q);
		trigIn = 1'b0;
		spur = 1'b0;
		hostBoardReset = 1'b1;
		step(1);
		hostBoardReset = 1'b0;
		step(2);
		cmp("readyclr", 0, readyOut_q);
		cmp("frzclr", 0, cmpFrozen_q);
		cmp("rearm", 1, armed_status_out_q);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		step(5);
		sys_rst = 1'b0;
		cmp("rstarm", 1, armed_status_out_q);
		cmp("rstirq", 0, irqReq_q);
		loadDelay();
		// the first trigger after power-up doubles as the host's initialising soft trigger
		trigRun(8'h05);
		blocked();
		ackReset();
		trigRun(8'h30);
		blocked();
		ackReset();
		results();
	end
	initial begin
		#40000;
		mismatches++;
		results();
	end
endmodule
